// file: hdl/aad_add8.sv
// Byte adder with carry, digit carry and zero outputs
// Assumes purely combinational use by the datapath
`timescale 1ns/1ps
`default_nettype none

module aad_add8 #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] a,
   input  wire logic [WIDTH-1:0] b,
   output logic      [WIDTH-1:0] sum,
   output logic                  carry,
   output logic                  dcarry,
   output logic                  zero
);

   logic [WIDTH:0] full;
   logic [4:0]     low;

   if (WIDTH < 5) begin : g_width_check
      $error("aad_add8 needs WIDTH of at least 5");
   end

   // ----------------------------------------------------------------
   // Sum and flags
   // ----------------------------------------------------------------
   assign full   = {1'b0, a} + {1'b0, b};
   assign low    = {1'b0, a[3:0]} + {1'b0, b[3:0]};
   assign sum    = full[WIDTH-1:0];
   assign carry  = full[WIDTH];
   assign dcarry = low[4];
   assign zero   = (full[WIDTH-1:0] == '0);

endmodule

`default_nettype wire

// file: hdl/aad_core.sv
// Execution datapath for immediate add, immediate AND and file add
// Assumes a decoder offering one instruction word per cycle, a file
// register array read combinationally, and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "aad_defs.svh"

module aad_core #(
   parameter logic [6:0] TMR_ADDR = `AAD_TMR_ADDR
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // Decoder side
   input  wire logic        instr_valid,
   output logic             instr_ready,
   input  wire logic [13:0] instr_word,
   // File register array side
   output logic      [6:0]  file_rd_addr,
   input  wire logic [7:0]  file_rd_data,
   output logic             file_wr_en,
   output logic      [6:0]  file_wr_addr,
   output logic      [7:0]  file_wr_data,
   // Timer side
   input  wire logic        prescaler_assigned,
   output logic             prescaler_clear,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   logic [7:0]      accum_q, file_wr_data_q, add_b, add_sum, and_res;
   logic            carry_q, dcarry_q, zero_q, run_q, presc_clr_q;
   logic [31:0]     count_q, w_data_q, rdata_q, wr_data;
   logic [6:0]      file_wr_addr_q;
   logic [3:0]      aw_addr_q, w_strb_q, wr_addr, wr_strb;
   logic [1:0]      bresp_q, rresp_q;
   logic            file_wr_en_q, aw_held_q, w_held_q, bvalid_q, rvalid_q;
   aad_pkg::aad_op_t op;
   logic            fire, dest_file, add_c, add_dc, add_z;
   logic            aw_go, w_go, wr_have_a, wr_have_d, wr_do, wr_ok, ar_go;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   always_comb begin
      op = aad_pkg::AAD_OP_NONE;
      if ((instr_word & `AAD_MSK_ADD_IMM) == `AAD_PAT_ADD_IMM) begin
         op = aad_pkg::AAD_OP_ADD_IMM;
      end else if ((instr_word & `AAD_MSK_AND_IMM) == `AAD_PAT_AND_IMM)
      begin
         op = aad_pkg::AAD_OP_AND_IMM;
      end else if ((instr_word & `AAD_MSK_ADD_FILE) == `AAD_PAT_ADD_FILE)
      begin
         op = aad_pkg::AAD_OP_ADD_FILE;
      end
   end

   assign instr_ready  = run_q;
   assign fire         = instr_valid && run_q;
   assign dest_file    = instr_word[`AAD_DEST_BIT];
   assign file_rd_addr = instr_word[6:0];

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   assign add_b   = (op == aad_pkg::AAD_OP_ADD_FILE) ? file_rd_data
                                                     : instr_word[7:0];
   assign and_res = accum_q & instr_word[7:0];

   aad_add8 #(
      .WIDTH (8)
   ) u_add (
      .a      (accum_q),
      .b      (add_b),
      .sum    (add_sum),
      .carry  (add_c),
      .dcarry (add_dc),
      .zero   (add_z)
   );

   // ----------------------------------------------------------------
   // Bus write decode
   // ----------------------------------------------------------------
   assign aw_go     = s_axi_awvalid && s_axi_awready;
   assign w_go      = s_axi_wvalid && s_axi_wready;
   assign wr_have_a = aw_held_q || aw_go;
   assign wr_have_d = w_held_q || w_go;
   assign wr_do     = wr_have_a && wr_have_d && !bvalid_q;
   assign wr_addr   = aw_held_q ? aw_addr_q : s_axi_awaddr;
   assign wr_data   = w_held_q ? w_data_q : s_axi_wdata;
   assign wr_strb   = w_held_q ? w_strb_q : s_axi_wstrb;
   assign wr_ok     = (wr_addr == `AAD_OFS_ACCUM)
                   || (wr_addr == `AAD_OFS_STATUS)
                   || (wr_addr == `AAD_OFS_CTRL)
                   || (wr_addr == `AAD_OFS_COUNT);

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         accum_q <= `AAD_RST_ACCUM;
      end else if (wr_do && wr_addr == `AAD_OFS_ACCUM && wr_strb[0]) begin
         accum_q <= wr_data[7:0];
      end else if (fire) begin
         case (op)
            aad_pkg::AAD_OP_ADD_IMM: accum_q <= add_sum;
            aad_pkg::AAD_OP_AND_IMM: accum_q <= and_res;
            aad_pkg::AAD_OP_ADD_FILE: begin
               if (!dest_file) begin
                  accum_q <= add_sum;
               end
            end
            default: accum_q <= accum_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         {zero_q, dcarry_q, carry_q} <= `AAD_RST_FLAGS;
      end else if (wr_do && wr_addr == `AAD_OFS_STATUS && wr_strb[0]) begin
         carry_q  <= wr_data[`AAD_ST_CARRY];
         dcarry_q <= wr_data[`AAD_ST_DCARRY];
         zero_q   <= wr_data[`AAD_ST_ZERO];
      end else if (fire) begin
         case (op)
            aad_pkg::AAD_OP_ADD_IMM,
            aad_pkg::AAD_OP_ADD_FILE: begin
               carry_q  <= add_c;
               dcarry_q <= add_dc;
               zero_q   <= add_z;
            end
            aad_pkg::AAD_OP_AND_IMM: zero_q <= (and_res == 8'h00);
            default: zero_q <= zero_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // File write-back and prescaler clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         file_wr_en_q   <= 1'b0;
         file_wr_addr_q <= 7'h00;
         file_wr_data_q <= 8'h00;
         presc_clr_q    <= 1'b0;
      end else begin
         file_wr_en_q <= fire && op == aad_pkg::AAD_OP_ADD_FILE
                      && dest_file;
         presc_clr_q  <= fire && op == aad_pkg::AAD_OP_ADD_FILE
                      && dest_file && instr_word[6:0] == TMR_ADDR
                      && prescaler_assigned;
         if (fire && op == aad_pkg::AAD_OP_ADD_FILE && dest_file) begin
            file_wr_addr_q <= instr_word[6:0];
            file_wr_data_q <= add_sum;
         end
      end
   end

   assign file_wr_en      = file_wr_en_q;
   assign file_wr_addr    = file_wr_addr_q;
   assign file_wr_data    = file_wr_data_q;
   assign prescaler_clear = presc_clr_q;

   // ----------------------------------------------------------------
   // Control and instruction count
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         run_q <= `AAD_RST_RUN;
      end else if (wr_do && wr_addr == `AAD_OFS_CTRL && wr_strb[0]) begin
         run_q <= wr_data[`AAD_CTRL_RUN];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_q <= 32'h0000_0000;
      end else if (wr_do && wr_addr == `AAD_OFS_COUNT) begin
         count_q <= 32'h0000_0000;
      end else if (fire && op != aad_pkg::AAD_OP_NONE) begin
         count_q <= count_q + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_held_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
      end else begin
         if (wr_do) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
         end else begin
            if (aw_go) begin
               aw_held_q <= 1'b1;
               aw_addr_q <= s_axi_awaddr;
            end
            if (w_go) begin
               w_held_q <= 1'b1;
               w_data_q <= s_axi_wdata;
               w_strb_q <= s_axi_wstrb;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `AAD_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? `AAD_RESP_OKAY : `AAD_RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channels
   // ----------------------------------------------------------------
   assign s_axi_arready = !rvalid_q;
   assign ar_go         = s_axi_arvalid && !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `AAD_RESP_OKAY;
      end else if (ar_go) begin
         rvalid_q <= 1'b1;
         rresp_q  <= `AAD_RESP_OKAY;
         case (s_axi_araddr)
            `AAD_OFS_ACCUM:  rdata_q <= {24'h000000, accum_q};
            `AAD_OFS_STATUS: rdata_q <= {29'h0, zero_q, dcarry_q, carry_q};
            `AAD_OFS_CTRL:   rdata_q <= {31'h0, run_q};
            `AAD_OFS_COUNT:  rdata_q <= count_q;
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= `AAD_RESP_DECERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: inc/aad_defs.svh
// Constants for the accumulator add/AND datapath and its register bus
// Assumes inclusion by bare name from files under hdl/ and inc/
`ifndef AAD_DEFS_SVH
`define AAD_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define AAD_OFS_ACCUM   4'h0
`define AAD_OFS_STATUS  4'h4
`define AAD_OFS_CTRL    4'h8
`define AAD_OFS_COUNT   4'hc

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define AAD_ST_CARRY    0
`define AAD_ST_DCARRY   1
`define AAD_ST_ZERO     2
`define AAD_CTRL_RUN    0
`define AAD_RST_ACCUM   8'h00
`define AAD_RST_FLAGS   3'h0
`define AAD_RST_RUN     1'b1

// ----------------------------------------------------------------------
// Instruction word decode
// ----------------------------------------------------------------------
`define AAD_MSK_ADD_IMM  14'h3e00
`define AAD_PAT_ADD_IMM  14'h3e00
`define AAD_MSK_AND_IMM  14'h3f00
`define AAD_PAT_AND_IMM  14'h3900
`define AAD_MSK_ADD_FILE 14'h3f00
`define AAD_PAT_ADD_FILE 14'h0700
`define AAD_DEST_BIT     7
`define AAD_TMR_ADDR     7'h01

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define AAD_RESP_OKAY    2'h0
`define AAD_RESP_DECERR  2'h3

`endif

// file: inc/aad_pkg.sv
// Types shared by the accumulator datapath files
// Assumes nothing of its surroundings
`default_nettype none

package aad_pkg;

   // -------------------------------------------------------------------
   // Instruction classes
   // -------------------------------------------------------------------
   typedef enum {
      AAD_OP_NONE,
      AAD_OP_ADD_IMM,
      AAD_OP_AND_IMM,
      AAD_OP_ADD_FILE
   } aad_op_t;

endpackage

`default_nettype wire

// file: verif/aad_core_chk_sva.sv
// Assertion checker for the datapath instruction and file-write ports
// Assumes binding onto aad_core; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module aad_core_chk #(
   parameter logic [6:0] TMR_ADDR = 7'h01
) (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        instr_valid,
   input wire logic        instr_ready,
   input wire logic [13:0] instr_word,
   input wire logic [6:0]  file_rd_addr,
   input wire logic        file_wr_en,
   input wire logic [6:0]  file_wr_addr,
   input wire logic        prescaler_assigned,
   input wire logic        prescaler_clear
);
   // -------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------
   logic fire, af0, af1, imm, psc;
   assign fire = instr_valid && instr_ready;
   assign af0 = fire && ((instr_word & 14'h3f80) == 14'h0700);
   assign af1 = fire && ((instr_word & 14'h3f80) == 14'h0780);
   assign imm = fire && ((instr_word & 14'h3e00) == 14'h3e00
                || (instr_word & 14'h3f00) == 14'h3900);
   assign psc = af1 && instr_word[6:0] == TMR_ADDR && prescaler_assigned;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_rd_addr; file_rd_addr == instr_word[6:0]; endproperty
   a_rd_addr: assert property (p_rd_addr)
      else $error("file read address wrong");
   property p_wr_d1;
      af1 |=> file_wr_en && file_wr_addr == $past(instr_word[6:0]);
   endproperty
   a_wr_d1: assert property (p_wr_d1)
      else $error("file write-back missing");
   property p_wr_d0; af0 |=> !file_wr_en; endproperty
   a_wr_d0: assert property (p_wr_d0)
      else $error("file written with accumulator target");
   property p_imm; imm |-> ##1 (!file_wr_en && !prescaler_clear); endproperty
   a_imm: assert property (p_imm)
      else $error("immediate op touched file side");
   property p_wr_cause; file_wr_en |-> $past(af1); endproperty
   a_wr_cause: assert property (p_wr_cause)
      else $error("file write without cause");
   property p_psc_set; psc |-> ##1 prescaler_clear ##0 file_wr_en; endproperty
   a_psc_set: assert property (p_psc_set)
      else $error("prescaler clear missing");
   property p_psc_cause; prescaler_clear |-> $past(psc); endproperty
   a_psc_cause: assert property (p_psc_cause)
      else $error("prescaler clear without cause");
   property p_psc_none; af1 && !prescaler_assigned |=> !prescaler_clear;
   endproperty
   a_psc_none: assert property (p_psc_none)
      else $error("prescaler cleared while unassigned");
   c_d0: cover property (af0);
   c_d1: cover property (af1);
   c_psc: cover property (psc ##1 prescaler_clear);
endmodule
bind aad_core aad_core_chk #(.TMR_ADDR(TMR_ADDR)) aad_core_chk_inst (
   .clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid),
   .instr_ready(instr_ready), .instr_word(instr_word),
   .file_rd_addr(file_rd_addr), .file_wr_en(file_wr_en),
   .file_wr_addr(file_wr_addr), .prescaler_assigned(prescaler_assigned),
   .prescaler_clear(prescaler_clear));
`default_nettype wire

// file: verif/aad_file_model.sv
// File register array model, combinational read, clocked write
// Assumes the datapath read and write ports on one clock
`timescale 1ns/1ps
`default_nettype none
module aad_file_model (
   input wire logic       clk_sys,
   input wire logic [6:0] rd_addr,
   output logic     [7:0] rd_data,
   input wire logic       wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem [128];
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 59 + 7);
   assign rd_data = mem[rd_addr];
   always @(posedge clk_sys) if (wr_en) mem[wr_addr] <= wr_data;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the accumulator datapath
// Assumes aad_core, the file model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_sys, srst, instr_valid, instr_ready, prescaler_assigned;
   logic        prescaler_clear, file_wr_en, awvalid, awready, wvalid;
   logic        wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [13:0] instr_word, w;
   logic [6:0]  file_rd_addr, file_wr_addr;
   logic [7:0]  file_rd_data, file_wr_data, k, acc_m;
   logic [3:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, cnt_m;
   logic [1:0]  bresp, rresp;
   logic [2:0]  st_m, op;
   logic        run_m;
   logic [33:0] rq [$];
   logic [16:0] wq [$];
   logic [1:0]  bq [$];
   int          failures, n_checks, cyc;
   aad_core aad_core_inst (.clk_sys(clk_sys), .srst(srst),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .instr_word(instr_word), .file_rd_addr(file_rd_addr),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
      .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
      .prescaler_assigned(prescaler_assigned),
      .prescaler_clear(prescaler_clear), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   aad_file_model aad_file_model_inst (.clk_sys(clk_sys),
      .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr_en(file_wr_en),
      .wr_addr(file_wr_addr), .wr_data(file_wr_data));
   always #10 clk_sys = ~clk_sys;
   // -------------------------------------------------------------------
   // Compare, bus and instruction tasks
   // -------------------------------------------------------------------
   task automatic wrap_up();
      if (rq.size() || wq.size() || bq.size()) begin
         failures++;
         $display("ERROR %0t expected results never seen", $time);
      end
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_wr(input logic [16:0] got, input logic [16:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t file write %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_wrsp(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t write response %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      bq.push_back((a[1:0] != 2'h0) ? 2'h3 : 2'h0);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      case (a)
         4'h0: acc_m = d[7:0];
         4'h4: st_m = d[2:0];
         4'h8: run_m = d[0];
         4'hc: cnt_m = 32'h0;
         default: ;
      endcase
   endtask
   task automatic axr(input logic [3:0] a);
      logic [31:0] e;
      e = (a == 4'h0) ? {24'h0, acc_m} : (a == 4'h4) ? {29'h0, st_m} :
          (a == 4'h8) ? {31'h0, run_m} : (a == 4'hc) ? cnt_m : 32'h0;
      rq.push_back({(a[1:0] != 2'h0) ? 2'h3 : 2'h0, e});
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic ins(input logic [13:0] iw, input logic keep);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] x;
      x = iw[13] ? iw[7:0] : aad_file_model_inst.mem[iw[6:0]];
      s = {1'b0, acc_m} + {1'b0, x};
      h = {1'b0, acc_m[3:0]} + {1'b0, x[3:0]};
      if (iw[13:8] == 6'h39) begin
         acc_m = acc_m & x;
         st_m[2] = (acc_m == 8'h0);
         cnt_m++;
      end else if (iw[13:9] == 5'h1f || iw[13:8] == 6'h07) begin
         st_m = {s[7:0] == 8'h0, h[4], s[8]};
         cnt_m++;
         if (iw[13:8] == 6'h07 && iw[7])
            wq.push_back({1'b1, iw[6:0] == 7'h01 && prescaler_assigned,
                          iw[6:0], s[7:0]});
         else
            acc_m = s[7:0];
      end
      instr_valid <= 1'b1;
      instr_word <= iw;
      do @(posedge clk_sys); while (!instr_ready);
      if (!keep) instr_valid <= 1'b0;
   endtask
   // -------------------------------------------------------------------
   // Result watcher and timeout
   // -------------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rvalid && rready)
         chk_rd({rresp, rdata}, rq.pop_front());
      if (!srst && (file_wr_en || prescaler_clear))
         chk_wr({file_wr_en, prescaler_clear, file_wr_addr, file_wr_data},
                wq.size() ? wq.pop_front() : 17'hx);
      if (bvalid && bready)
         chk_wrsp(bresp, bq.pop_front());
      cyc++;
      if (cyc == 20000) begin
         failures++;
         wrap_up();
      end
   end
   initial begin
      {clk_sys, instr_valid, prescaler_assigned, awvalid, wvalid} = '0;
      {bready, arvalid, rready, awaddr, araddr, wdata, instr_word} = '0;
      {acc_m, st_m, cnt_m, failures, n_checks, cyc} = '0;
      run_m = 1'b1;
      srst = 1'b1;
      void'($urandom(23394));
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) axr((i == 4) ? 4'h2 : 4'(i * 4));
      axw(4'h0, 32'h10);
      ins(14'h3e15, 1'b1);
      ins(14'h395f, 1'b0);
      axr(4'h0);
      axr(4'h4);
      ins(14'h0785, 1'b1);
      ins(14'h0786, 1'b1);
      ins(14'h0707, 1'b0);
      axr(4'h0);
      axw(4'h2, 32'hff);
      axw(4'h8, 32'h0);
      instr_word <= 14'h3e01;
      instr_valid <= 1'b1;
      repeat (3) @(posedge clk_sys);
      instr_valid <= 1'b0;
      axr(4'h8);
      axr(4'h0);
      axw(4'h8, 32'h1);
      for (int i = 0; i < 80; i++) begin
         op = 3'($urandom_range(0, 5));
         k = 8'($urandom);
         prescaler_assigned <= 1'($urandom);
         axw(4'h0, $urandom);
         axw(4'h4, $urandom);
         w = (op == 0) ? {6'h3e, k} : (op == 1) ? {6'h3f, k} :
             (op == 2) ? {6'h39, k} : (op == 5) ? {6'h3a, k} :
             {6'h07, op == 3'h4, k[0] ? 7'h01 : k[7:1]};
         ins(w, 1'b0);
         axr(4'h0);
         axr(4'h4);
      end
      axr(4'hc);
      axw(4'hc, 32'h0);
      axr(4'hc);
      repeat (3) @(posedge clk_sys);
      wrap_up();
   end
endmodule
`default_nettype wire
